// >>> core/bfs_defines.svh
// How it works
// - Taken branch first clears execute and store-compare triggers.
// - Taken: branch address plus 8 on first adder input loads the counter.
// - Target in last halfword: request at counter, gate it, keep last half.
// - Then counter plus 8, gate next doubleword, normal end.
// - Taken elsewhere: gate target and chosen halfword, then branch end.
// - Branch end: format from storage bus, address from branch address if taken, else counter plus 8.
// - Untaken at last halfword: counter plus 8 into counter and address.
// - Then if execute set: counter minus 8, normal end; else branch end.
// - Untaken elsewhere: no refill, normal end from halfword and counter.
// - Store-compare set: subtract 8 or 16, request that doubleword.
// - Indexed untaken at halfword 0: plus 8, gate, first halfword out.
// - Then trigger clear: branch end; set: minus 8 and normal end.
// - Link word: next address, length 1, or 2 under execute, cc, mask.
// - Link register form with zero second register field is untaken.
// - Link: counter minus 16 at last half under execute, else minus 8.
// - Link store happens whether taken or not.
// - Taken requests at branch address; untaken refills only if needed.
// - Conditional branch taken when mask bit of weight 8,4,2,1 for codes 0..3 is set (BCR: and second field nonzero).
`ifndef BFS_DEFINES_SVH
`define BFS_DEFINES_SVH
`define BFS_OFF_CTRL 6'h00
`define BFS_OFF_INSTR 6'h04
`define BFS_OFF_PSW 6'h08
`define BFS_OFF_IC 6'h0C
`define BFS_OFF_BRADDR 6'h10
`define BFS_OFF_HWREG 6'h14
`define BFS_OFF_QLO 6'h18
`define BFS_OFF_QHI 6'h1C
`define BFS_OFF_LINK 6'h20
`define BFS_OP_BCR 8'h07
`define BFS_OP_BC 8'h47
`define BFS_OP_BRANCH_LINK_REGISTER_FORM 8'h05
`define BFS_DW_STEP 24'h000008
`define BFS_HW_LAST 2'h3
`define BFS_HW_FIRST 2'h0
`define BFS_MEM_LAT 2'h3
`define BFS_ILC_PLAIN 2'h1
`define BFS_ILC_EXEC 2'h2
`define BFS_ADDR_RST 24'h000000
`define BFS_RESP_OKAY 2'h0
`define BFS_RESP_SLVERR 2'h2
`define BFS_PSW_EXEC 6
`define BFS_PSW_PSC 7
`endif

// >>> core/bfs_pkg.sv
package bfs_pkg;
  typedef enum logic [2:0] {
    BFS_IDLE = 3'b000,
    BFS_LINK = 3'b001,
    BFS_WAIT = 3'b010,
    BFS_TREQ = 3'b011,
    BFS_TINC = 3'b100,
    BFS_TWAIT = 3'b101,
    BFS_UEX = 3'b110,
    BFS_PSC = 3'b111
  } bfs_state_t;
  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } bfs_stor_t;
  typedef struct packed {
    logic we;
    logic [3:0] sel;
    logic [31:0] data;
  } bfs_link_t;
  typedef struct packed {
    logic normal;
    logic branch;
    logic [15:0] fmt;
    logic [23:0] addr;
  } bfs_end_t;
endpackage

// >>> core/bfs_adder.sv
`timescale 1ns/1ps
`default_nettype none
`include "bfs_defines.svh"
module bfs_adder (
  input wire logic [23:0] first_adder_input,
  input wire logic [23:0] second_adder_input,
  input wire logic use_second,
  input wire logic subtract,
  input wire logic double_step,
  output logic [23:0] sum
);
  logic [23:0] operand;
  logic [23:0] step;
  // Operand select and 8 or 16 step
  assign operand = use_second ? second_adder_input : first_adder_input;
  assign step = double_step ? (`BFS_DW_STEP << 1) : `BFS_DW_STEP;
  assign sum = subtract ? operand - step : operand + step;
endmodule // bfs_adder
`default_nettype wire

// >>> core/bfs_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "bfs_defines.svh"
module bfs_seq
  import bfs_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [63:0] storage_output_bus,
  output bfs_stor_t stor_o,
  output bfs_link_t link_o,
  output bfs_end_t end_o
);
  // Architectural state
  bfs_state_t state_reg, state_next;
  logic [23:0] ic_reg, ic_next;
  logic [23:0] braddr_reg, braddr_next;
  logic [63:0] q_reg, q_next;
  logic [15:0] hw_reg, hw_next;
  logic [15:0] instr_reg;
  logic [1:0] cc_reg;
  logic [3:0] mask_reg;
  logic exec_reg, exec_next;
  logic psc_reg, psc_next;
  logic taken_reg, taken_next;
  logic refill_reg, refill_next;
  logic [1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic last_branch_reg, last_branch_next;
  bfs_stor_t stor_next;
  bfs_link_t link_next;
  bfs_end_t end_next;
  // Bus slave state
  logic aw_held_reg, w_held_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // Instruction fields
  wire [7:0] opcode = instr_reg[15:8];
  wire [3:0] field_r1 = instr_reg[7:4];
  wire [3:0] field_r2 = instr_reg[3:0];
  wire is_bc = opcode == `BFS_OP_BC;
  wire is_branch_link_register_form = opcode == `BFS_OP_BRANCH_LINK_REGISTER_FORM;
  wire busy = state_reg != BFS_IDLE;
  wire [1:0] ic_hw = ic_reg[2:1];
  wire [1:0] d_hw = braddr_reg[2:1];

  // Branch decision from mask and second field
  wire mask_hit = mask_reg[2'h3 - cc_reg];
  wire r2_nonzero = field_r2 != 4'h0;
  wire taken_now = is_branch_link_register_form ? r2_nonzero
                 : is_bc ? mask_hit : (mask_hit & r2_nonzero);
  wire refill_now = (ic_hw == `BFS_HW_LAST)
                  | (is_bc & (ic_hw == `BFS_HW_FIRST));
  wire data_here = cnt_reg == 2'h0;

  // Write decode
  wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire wr_ctrl = wr_fire & (waddr_reg == `BFS_OFF_CTRL);
  wire wr_instr = wr_fire & (waddr_reg == `BFS_OFF_INSTR);
  wire wr_psw = wr_fire & (waddr_reg == `BFS_OFF_PSW);
  wire wr_ic = wr_fire & (waddr_reg == `BFS_OFF_IC);
  wire wr_d = wr_fire & (waddr_reg == `BFS_OFF_BRADDR);
  wire wr_known = wr_ctrl | wr_instr | wr_psw | wr_ic | wr_d;
  wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                       {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0] psw_word = {24'h000000, psc_reg, exec_reg, mask_reg, cc_reg};
  wire [31:0] s_axi_wdata_hold = wdata_reg;
  wire [31:0] psw_new = (psw_word & ~wmask) | (s_axi_wdata_hold & wmask);
  wire go = wr_ctrl & wstrb_reg[0] & wdata_reg[0] & ~busy;

  // Read decode
  wire [ADDR_W-1:0] ra = s_axi_araddr;
  wire rd_hit = (ra == `BFS_OFF_CTRL) | (ra == `BFS_OFF_INSTR)
              | (ra == `BFS_OFF_PSW) | (ra == `BFS_OFF_IC)
              | (ra == `BFS_OFF_BRADDR) | (ra == `BFS_OFF_HWREG)
              | (ra == `BFS_OFF_QLO) | (ra == `BFS_OFF_QHI)
              | (ra == `BFS_OFF_LINK);
  wire [31:0] rd_val =
      (ra == `BFS_OFF_CTRL) ? {29'h0, last_branch_reg, done_reg, busy} :
      (ra == `BFS_OFF_INSTR) ? {16'h0000, instr_reg} :
      (ra == `BFS_OFF_PSW) ? psw_word :
      (ra == `BFS_OFF_IC) ? {8'h00, ic_reg} :
      (ra == `BFS_OFF_BRADDR) ? {8'h00, braddr_reg} :
      (ra == `BFS_OFF_HWREG) ? {16'h0000, hw_reg} :
      (ra == `BFS_OFF_QLO) ? q_reg[31:0] :
      (ra == `BFS_OFF_QHI) ? q_reg[63:32] :
      (ra == `BFS_OFF_LINK) ? link_o.data : 32'h00000000;

  // Halfword picked out of a doubleword, first halfword on the left
  function automatic logic [15:0] pick_hw(input logic [63:0] dw,
                                          input logic [1:0] sel);
    logic [5:0] base;
    base = 6'h30 - {sel, 4'h0};
    pick_hw = dw[base +: 16];
  endfunction

  // Adder steering per step
  logic add_second, add_sub, add_double;
  logic [23:0] add_sum;
  always_comb begin
    add_second = 1'b1;
    add_sub = 1'b0;
    add_double = 1'b0;
    unique case (state_reg)
      BFS_LINK, BFS_PSC: begin
        add_sub = 1'b1;
        add_double = (ic_hw == `BFS_HW_LAST) & exec_reg;
      end
      BFS_WAIT: add_second = ~taken_reg;
      BFS_UEX: add_sub = 1'b1;
      default: add_second = 1'b1;
    endcase
  end

  bfs_adder u_adder (
    .first_adder_input(braddr_reg),
    .second_adder_input(ic_reg),
    .use_second(add_second),
    .subtract(add_sub),
    .double_step(add_double),
    .sum(add_sum)
  );

  // Sequencer, one micro-step per clock
  always_comb begin
    state_next = state_reg;
    ic_next = ic_reg;
    braddr_next = braddr_reg;
    q_next = q_reg;
    hw_next = hw_reg;
    exec_next = exec_reg;
    psc_next = psc_reg;
    taken_next = taken_reg;
    refill_next = refill_reg;
    cnt_next = (cnt_reg != 2'h0) ? cnt_reg - 2'h1 : cnt_reg;
    done_next = done_reg;
    last_branch_next = last_branch_reg;
    stor_next = '{req: 1'b0, addr: stor_o.addr};
    link_next = '{we: 1'b0, sel: link_o.sel, data: link_o.data};
    end_next = '{normal: 1'b0, branch: 1'b0, fmt: end_o.fmt,
                 addr: end_o.addr};
    if (wr_psw & ~busy) begin
      exec_next = psw_new[`BFS_PSW_EXEC];
      psc_next = psw_new[`BFS_PSW_PSC];
    end
    if (wr_ic & ~busy) begin
      ic_next = (ic_reg & ~wmask[23:0]) | (wdata_reg[23:0] & wmask[23:0]);
    end
    if (wr_d & ~busy) begin
      braddr_next = (braddr_reg & ~wmask[23:0])
                  | (wdata_reg[23:0] & wmask[23:0]);
    end
    unique case (state_reg)
      BFS_IDLE: begin
        if (go) begin
          done_next = 1'b0;
          taken_next = taken_now;
          refill_next = refill_now;
          if (taken_now) begin
            exec_next = 1'b0;
            psc_next = 1'b0;
            stor_next = '{req: 1'b1, addr: braddr_reg};
            cnt_next = `BFS_MEM_LAT;
          end else if (refill_now & ~psc_reg) begin
            stor_next = '{req: 1'b1, addr: ic_reg};
            cnt_next = `BFS_MEM_LAT;
          end
          if (is_branch_link_register_form) begin
            state_next = BFS_LINK;
          end else if (~taken_now & psc_reg) begin
            state_next = BFS_PSC;
          end else if (taken_now | refill_now) begin
            state_next = BFS_WAIT;
          end else begin
            end_next = '{normal: 1'b1, branch: 1'b0, fmt: hw_reg,
                         addr: ic_reg};
            state_next = BFS_IDLE;
            done_next = 1'b1;
            last_branch_next = 1'b0;
          end
        end
      end
      BFS_LINK: begin
        // Link word: length code, cc, mask, next address
        link_next.we = 1'b1;
        link_next.sel = field_r1;
        link_next.data = {exec_reg ? `BFS_ILC_EXEC : `BFS_ILC_PLAIN,
                          cc_reg, mask_reg, add_sum};
        if (~taken_reg & psc_reg) begin
          state_next = BFS_PSC;
        end else if (taken_reg | refill_reg) begin
          state_next = BFS_WAIT;
        end else begin
          end_next = '{normal: 1'b1, branch: 1'b0, fmt: hw_reg,
                       addr: ic_reg};
          state_next = BFS_IDLE;
          done_next = 1'b1;
          last_branch_next = 1'b0;
        end
      end
      BFS_WAIT: begin
        if (data_here) begin
          q_next = storage_output_bus;
          if (taken_reg) begin
            ic_next = add_sum;
            hw_next = pick_hw(storage_output_bus, d_hw);
            if (d_hw == `BFS_HW_LAST) begin
              state_next = BFS_TREQ;
            end else begin
              end_next = '{normal: 1'b0, branch: 1'b1,
                           fmt: pick_hw(storage_output_bus, d_hw),
                           addr: braddr_reg};
              state_next = BFS_IDLE;
              done_next = 1'b1;
              last_branch_next = 1'b1;
            end
          end else begin
            ic_next = add_sum;
            braddr_next = add_sum;
            if (is_bc & (ic_hw == `BFS_HW_FIRST)) begin
              hw_next = pick_hw(storage_output_bus, `BFS_HW_FIRST);
            end
            if (exec_reg) begin
              state_next = BFS_UEX;
            end else begin
              end_next = '{normal: 1'b0, branch: 1'b1,
                           fmt: pick_hw(storage_output_bus, add_sum[2:1]),
                           addr: add_sum};
              state_next = BFS_IDLE;
              done_next = 1'b1;
              last_branch_next = 1'b1;
            end
          end
        end
      end
      BFS_TREQ: begin
        stor_next = '{req: 1'b1, addr: ic_reg};
        cnt_next = `BFS_MEM_LAT;
        state_next = BFS_TINC;
      end
      BFS_TINC: begin
        ic_next = add_sum;
        state_next = BFS_TWAIT;
      end
      BFS_TWAIT: begin
        if (data_here) begin
          q_next = storage_output_bus;
          end_next = '{normal: 1'b1, branch: 1'b0, fmt: hw_reg,
                       addr: ic_reg};
          state_next = BFS_IDLE;
          done_next = 1'b1;
          last_branch_next = 1'b0;
        end
      end
      BFS_UEX: begin
        ic_next = add_sum;
        end_next = '{normal: 1'b1, branch: 1'b0, fmt: hw_reg,
                     addr: add_sum};
        state_next = BFS_IDLE;
        done_next = 1'b1;
        last_branch_next = 1'b0;
      end
      BFS_PSC: begin
        // Step back to the doubleword after the Execute
        ic_next = add_sum;
        stor_next = '{req: 1'b1, addr: add_sum};
        cnt_next = `BFS_MEM_LAT;
        psc_next = 1'b0;
        taken_next = 1'b0;
        refill_next = 1'b0;
        state_next = BFS_TWAIT;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BFS_IDLE;
      ic_reg <= `BFS_ADDR_RST;
      braddr_reg <= `BFS_ADDR_RST;
      q_reg <= 64'h0000000000000000;
      hw_reg <= 16'h0000;
      exec_reg <= 1'b0;
      psc_reg <= 1'b0;
      taken_reg <= 1'b0;
      refill_reg <= 1'b0;
      cnt_reg <= 2'h0;
      done_reg <= 1'b0;
      last_branch_reg <= 1'b0;
      stor_o <= '0;
      link_o <= '0;
      end_o <= '0;
    end else begin
      state_reg <= state_next;
      ic_reg <= ic_next;
      braddr_reg <= braddr_next;
      q_reg <= q_next;
      hw_reg <= hw_next;
      exec_reg <= exec_next;
      psc_reg <= psc_next;
      taken_reg <= taken_next;
      refill_reg <= refill_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      last_branch_reg <= last_branch_next;
      stor_o <= stor_next;
      link_o <= link_next;
      end_o <= end_next;
    end
  end

  // Software-held instruction and program status fields
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg <= 16'h0000;
      cc_reg <= 2'h0;
      mask_reg <= 4'h0;
    end else begin
      if (wr_instr & ~busy) begin
        instr_reg <= (instr_reg & ~wmask[15:0])
                   | (wdata_reg[15:0] & wmask[15:0]);
      end
      if (wr_psw & ~busy) begin
        cc_reg <= psw_new[1:0];
        mask_reg <= psw_new[5:2];
      end
    end
  end

  // Write channels taken in either order, answer after both
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BFS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `BFS_RESP_OKAY : `BFS_RESP_SLVERR;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel, one outstanding read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BFS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `BFS_RESP_OKAY : `BFS_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // bfs_seq
`default_nettype wire

// >>> dv/bfs_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bfs_seq_chk
  import bfs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [63:0] storage_output_bus,
  input wire bfs_stor_t stor_o,
  input wire bfs_link_t link_o,
  input wire bfs_end_t end_o
);
  logic [3:0] since_reg;
  logic [23:0] prev_addr_reg;
  wire logic any_end = end_o.normal | end_o.branch;

  // Age and address of the latest storage request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      since_reg <= 4'hF;
      prev_addr_reg <= 24'h000000;
    end else if (stor_o.req) begin
      since_reg <= 4'h0;
      prev_addr_reg <= stor_o.addr;
    end else if (since_reg != 4'hF) begin
      since_reg <= since_reg + 4'h1;
    end
  end

  function automatic logic [15:0] hw_pick(logic [63:0] dw, logic [1:0] k);
    return dw[63 - 16 * k -: 16];
  endfunction

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Request, end and link strobes
  req_gap_a: assert property (stor_o.req |=> !stor_o.req [*3])
    else $error("storage requests too close");
  end_kind_a: assert property (!(end_o.normal && end_o.branch))
    else $error("both end kinds at once");
  end_pulse_a: assert property (any_end |=> !any_end)
    else $error("end strobe longer than a cycle");
  link_pulse_a: assert property (link_o.we |=> !link_o.we)
    else $error("link strobe longer than a cycle");
  link_ilc_a: assert property (link_o.we |->
      (link_o.data[31:30] == 2'h1 || link_o.data[31:30] == 2'h2))
    else $error("bad length code in link word");
  // Branch end decodes straight off the storage bus
  br_fmt_a: assert property (end_o.branch |->
      end_o.fmt == hw_pick($past(storage_output_bus), end_o.addr[2:1]))
    else $error("branch end format not from storage bus");
  br_data_a: assert property (end_o.branch |-> $past(stor_o.req, 4))
    else $error("branch end not on data cycle");
  req_step_a: assert property ((stor_o.req && since_reg < 4'h9) |->
      stor_o.addr == prev_addr_reg + 24'h000008)
    else $error("follow-on request not one doubleword on");
  end_hold_a: assert property (!any_end |->
      $stable(end_o.addr) && $stable(end_o.fmt))
    else $error("end fields moved between ends");
endmodule // bfs_seq_chk

bind bfs_seq bfs_seq_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .storage_output_bus(storage_output_bus), .stor_o(stor_o),
  .link_o(link_o), .end_o(end_o));
`default_nettype wire

// >>> dv/bfs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfs_mem_model
  import bfs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire bfs_stor_t stor_o,
  output logic [63:0] storage_output_bus
);
  logic [1:0] pend_reg;
  logic [23:0] a1_reg, a2_reg;

  function automatic logic [15:0] hw_of(logic [23:0] a, logic [1:0] k);
    return {k, 2'h2, a[11:0]};
  endfunction

  // Three-cycle read pipe; bus churns outside the data cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 2'h0;
      a1_reg <= 24'h000000;
      a2_reg <= 24'h000000;
      storage_output_bus <= 64'h0;
    end else begin
      pend_reg <= {pend_reg[0], stor_o.req};
      a1_reg <= stor_o.addr;
      a2_reg <= a1_reg;
      if (pend_reg[1]) begin
        storage_output_bus <= {hw_of(a2_reg, 2'h0), hw_of(a2_reg, 2'h1),
                               hw_of(a2_reg, 2'h2), hw_of(a2_reg, 2'h3)};
      end else begin
        storage_output_bus <= ~storage_output_bus;
      end
    end
  end
endmodule // bfs_mem_model
`default_nettype wire

// >>> dv/test_branch_fetch_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_branch_fetch_sequencer
  import bfs_pkg::*;
;
  localparam logic [5:0] A_CTL = 6'h00, A_INS = 6'h04, A_PSW = 6'h08;
  localparam logic [5:0] A_CNT = 6'h0C, A_BRA = 6'h10, A_HW = 6'h14;
  localparam logic [5:0] A_QLO = 6'h18, A_QHI = 6'h1C, A_LNK = 6'h20;
  localparam logic [7:0] OP_CR = 8'h07, OP_CX = 8'h47, OP_LR = 8'h05;
  logic clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [63:0] storage_output_bus;
  bfs_stor_t stor_o;
  bfs_link_t link_o, lnk;
  bfs_end_t end_o;
  logic [23:0] req_a[$];
  logic end_n, end_b;
  logic [15:0] end_f;
  logic [23:0] end_ad;
  int errors = 0, checks = 0, lnk_n;

  bfs_seq DUT (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .storage_output_bus, .stor_o, .link_o, .end_o);
  bfs_mem_model u_mem (.clk_sys, .rst_n, .stor_o, .storage_output_bus);

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Record requests, link stores and end cycles
  always @(posedge clk_sys) begin
    if (stor_o.req === 1'b1) req_a.push_back(stor_o.addr);
    if (link_o.we === 1'b1) begin
      lnk = link_o;
      lnk_n++;
    end
    if (end_o.normal === 1'b1 || end_o.branch === 1'b1) begin
      end_n = end_o.normal;
      end_b = end_o.branch;
      end_f = end_o.fmt;
      end_ad = end_o.addr;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [5:0] a, input logic [31:0] v);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 40) chk(32'h0, 32'h1);
  endtask

  task automatic axi_rd(input logic [5:0] a);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40) chk(32'h0, 32'h1);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    axi_rd(a);
    chk(d, e);
  endtask

  // Load state, start, wait for idle
  task automatic run(input logic [7:0] op, input logic [3:0] f1, f2,
      input logic [1:0] cc, input logic [3:0] m, input logic ex, ps,
      input logic [23:0] cnt, br);
    int n;
    axi_wr(A_INS, {16'h0, op, f1, f2});
    axi_wr(A_PSW, {24'h0, ps, ex, m, cc});
    axi_wr(A_CNT, {8'h0, cnt});
    axi_wr(A_BRA, {8'h0, br});
    req_a.delete();
    end_n = 1'b0;
    end_b = 1'b0;
    lnk_n = 0;
    axi_wr(A_CTL, 32'h1);
    d = 32'h1;
    for (n = 0; n < 30 && d[0] !== 1'b0; n++) axi_rd(A_CTL);
    chk({31'h0, d[0]}, 32'h0);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    #3000000;
    errors++;
    print_verdict;
  end

  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk({31'h0, stor_o.req | link_o.we | end_o.normal | end_o.branch}, 0);
    axi_rd(6'h3C);
    chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
    axi_wr(6'h24, 32'h1);
    chk({30'h0, r}, 32'h2);
    // Byte strobes: only the low byte of the counter moves
    axi_wr(A_CNT, 32'h00ABCDEF);
    s_axi_wstrb <= 4'h1;
    axi_wr(A_CNT, 32'h00000012);
    s_axi_wstrb <= 4'hF;
    rdc(A_CNT, 32'h00ABCD12);
    $display("test bus done");
    // Taken, target mid-doubleword, triggers set beforehand
    run(OP_CR, 4'h1, 4'h3, 2'h0, 4'h8, 1'b1, 1'b1, 24'h000100, 24'h001234);
    chk(req_a.size(), 1);
    chk(req_a[0], 32'h1234);
    chk(end_b, 1);
    chk(end_f, 32'hA234);
    chk(end_ad, 32'h1234);
    rdc(A_CNT, 32'h123C);
    rdc(A_PSW, 32'h20);
    rdc(A_HW, 32'hA234);
    rdc(A_QLO, 32'hA234E234);
    rdc(A_QHI, 32'h22346234);
    rdc(A_CTL, 32'h6);
    $display("test taken done");
    // Taken, target in last halfword
    run(OP_CR, 4'h1, 4'h3, 2'h0, 4'h8, 1'b0, 1'b0, 24'h000100, 24'h000106);
    chk(req_a[1], 32'h10E);
    chk(end_n, 1);
    rdc(A_CNT, 32'h116);
    rdc(A_HW, 32'hE106);
    rdc(A_QLO, 32'hA10EE10E);
    rdc(A_CTL, 32'h2);
    $display("test taken last done");
    // Untaken at last halfword, both execute states
    run(OP_CR, 4'h1, 4'h3, 2'h0, 4'h0, 1'b0, 1'b0, 24'h000206, 24'h001234);
    chk(req_a[0], 32'h206);
    chk(end_b, 1);
    chk(end_f, 32'hE206);
    rdc(A_CNT, 32'h20E);
    rdc(A_BRA, 32'h20E);
    run(OP_CR, 4'h1, 4'h3, 2'h0, 4'h0, 1'b1, 1'b0, 24'h000206, 24'h001234);
    chk(end_n, 1);
    rdc(A_CNT, 32'h206);
    // Untaken, no refill; then store-compare refetch
    run(OP_CR, 4'h1, 4'h3, 2'h0, 4'h0, 1'b0, 1'b0, 24'h000202, 24'h001234);
    chk(req_a.size(), 0);
    chk(end_n, 1);
    chk(end_ad, 32'h202);
    run(OP_CR, 4'h1, 4'h3, 2'h0, 4'h0, 1'b0, 1'b1, 24'h000302, 24'h001234);
    chk(req_a[0], 32'h2FA);
    rdc(A_CNT, 32'h2FA);
    $display("test untaken done");
    // Indexed form untaken at first halfword
    run(OP_CX, 4'h1, 4'h3, 2'h0, 4'h0, 1'b0, 1'b0, 24'h000400, 24'h001234);
    chk(req_a[0], 32'h400);
    chk(end_b, 1);
    rdc(A_CNT, 32'h408);
    rdc(A_BRA, 32'h408);
    rdc(A_HW, 32'h2400);
    run(OP_CX, 4'h1, 4'h3, 2'h0, 4'h0, 1'b1, 1'b0, 24'h000400, 24'h001234);
    chk(end_n, 1);
    rdc(A_CNT, 32'h400);
    $display("test indexed done");
    // Branch and link, taken then untaken under execute
    run(OP_LR, 4'h5, 4'h7, 2'h2, 4'hA, 1'b0, 1'b0, 24'h000502, 24'h000600);
    chk(lnk_n, 1);
    chk(lnk.sel, 32'h5);
    chk(lnk.data, 32'h6A0004FA);
    rdc(A_LNK, 32'h6A0004FA);
    chk(end_b, 1);
    run(OP_LR, 4'h5, 4'h0, 2'h1, 4'h3, 1'b1, 1'b0, 24'h000506, 24'h000600);
    chk(lnk_n, 1);
    chk(lnk.data, 32'h930004F6);
    chk(req_a[0], 32'h506);
    $display("test link done");
    // Every condition code against every single mask bit
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 4; j++) begin
        run(OP_CX, 4'h1, 4'h3, 2'(c), 4'h8 >> j, 1'b0, 1'b0, 24'h000702,
            24'h000800);
        chk(end_b, (c == j));
        chk(req_a.size(), (c == j));
      end
    end
    $display("test mask done");
    print_verdict;
  end
endmodule // test_branch_fetch_sequencer
`default_nettype wire
